// ===== design/dmu_pkg.sv
// Constants shared by the upper-channel DMA control port
package dmu_pkg;

  localparam int          NCH            = 4;
  localparam int          SEL_W          = 2;

  // I/O port addresses
  localparam logic [7:0]  ADDR_STAT_CMD  = 8'hD0;
  localparam logic [7:0]  ADDR_SWREQ     = 8'hD2;
  localparam logic [7:0]  ADDR_MASK1     = 8'hD4;
  localparam logic [7:0]  ADDR_MODE      = 8'hD6;
  localparam logic [7:0]  ADDR_MCLR      = 8'hDA;
  localparam logic [7:0]  ADDR_MASK_CLR  = 8'hDC;
  localparam logic [7:0]  ADDR_MASK_ALL  = 8'hDE;

  // Command register fields
  localparam int          CMD_ACK_HI     = 7;
  localparam int          CMD_REQ_LO     = 6;
  localparam int          CMD_ROTATE     = 4;
  localparam int          CMD_COMPRESS   = 3;
  localparam int          CMD_DISABLE    = 2;
  localparam int          CMD_ADDR_HOLD  = 1;
  localparam int          CMD_MEM2MEM    = 0;
  localparam logic [7:0]  CMD_RESET      = 8'h00;
  localparam logic [7:0]  CMD_WMASK      = 8'hDF;

  // Status register fields
  localparam int          ST_REQ_LSB     = 4;
  localparam int          ST_TC_LSB      = 0;
  localparam logic [3:0]  TC_RESET       = 4'h0;

  // Request, mask and mode write fields
  localparam int          SEL_LSB        = 0;
  localparam int          REQ_GO_BIT     = 2;
  localparam int          MASK_SET_BIT   = 2;
  localparam int          MODE_SEL_LSB   = 6;
  localparam logic [1:0]  MODE_DEMAND    = 2'h0;
  localparam logic [1:0]  MODE_SINGLE    = 2'h1;
  localparam logic [1:0]  MODE_BLOCK     = 2'h2;
  localparam logic [1:0]  MODE_CASCADE   = 2'h3;
  localparam logic [7:0]  MODE_RESET     = 8'h00;

  // Reset and clear values, read filler
  localparam logic [3:0]  MASK_RESET     = 4'h0;
  localparam logic [3:0]  MASK_ALL_SET   = 4'hF;
  localparam logic [7:0]  UNDEF_RDATA    = 8'hFF;
  localparam logic [7:0]  RDATA_RESET    = 8'h00;

endpackage

// ===== design/dmu_arbiter.sv
// Fixed or rotating priority selector for the four upper channels
`timescale 1ns/10ps
`default_nettype none
module dmu_arbiter
  import dmu_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [NCH-1:0]   req,
  input  wire logic             rotate,
  input  wire logic             take,
  input  wire logic [SEL_W-1:0] taken_ch,
  output logic                  win_valid,
  output logic [SEL_W-1:0]      win_ch
);

  logic [SEL_W-1:0] top_reg;
  logic [SEL_W-1:0] top_next;
  logic [SEL_W-1:0] idx;

  ////////////////////////////////////////////////////////////////////////
  // Search runs from the lowest-priority channel to top_reg; the last hit wins
  always_comb begin
    idx       = '0;
    win_valid = 1'b0;
    win_ch    = '0;
    for (int k = NCH - 1; k >= 0; k--) begin
      idx = SEL_W'(top_reg + SEL_W'(k));
      if (req[idx]) begin
        win_valid = 1'b1;
        win_ch    = idx;
      end
    end
  end

  always_comb begin
    top_next = top_reg;
    if (!rotate) begin
      top_next = '0;
    end else if (take) begin
      top_next = SEL_W'(taken_ch + 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      top_reg <= '0;
    end else begin
      top_reg <= top_next;
    end
  end

endmodule
`default_nettype wire

// ===== design/dmu_sequencer.sv
// Word transfer cycle sequencer, normal or compressed timing
`timescale 1ns/10ps
`default_nettype none
module dmu_sequencer
  import dmu_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic start,
  input  wire logic abort,
  input  wire logic compressed,
  input  wire logic last_word,
  output logic      done,
  output logic      cmd_strobe,
  output logic      tc_strobe
);

  typedef enum logic [4:0] {
    SQ_IDLE = 5'b00001,
    SQ_ADDR = 5'b00010,
    SQ_WAIT = 5'b00100,
    SQ_CMD  = 5'b01000,
    SQ_DONE = 5'b10000
  } dmu_seq_e;

  dmu_seq_e sq_reg;
  dmu_seq_e sq_next;
  logic     cmd_reg;
  logic     cmd_next;
  logic     tc_reg;
  logic     tc_next;

  assign done       = (sq_reg == SQ_DONE);
  assign cmd_strobe = cmd_reg;
  assign tc_strobe  = tc_reg;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    sq_next = sq_reg;
    unique case (sq_reg)
      SQ_IDLE: if (start) sq_next = SQ_ADDR;
      SQ_ADDR: sq_next = compressed ? SQ_CMD : SQ_WAIT;
      SQ_WAIT: sq_next = SQ_CMD;
      SQ_CMD:  sq_next = SQ_DONE;
      SQ_DONE: sq_next = start ? SQ_ADDR : SQ_IDLE;
      default: sq_next = SQ_IDLE;
    endcase
    if (abort) begin
      sq_next = SQ_IDLE;
    end
    cmd_next = (sq_next == SQ_CMD) || (sq_next == SQ_DONE);
    tc_next  = (sq_next == SQ_CMD) && last_word;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sq_reg  <= SQ_IDLE;
      cmd_reg <= 1'b0;
      tc_reg  <= 1'b0;
    end else begin
      sq_reg  <= sq_next;
      cmd_reg <= cmd_next;
      tc_reg  <= tc_next;
    end
  end

endmodule
`default_nettype wire

// ===== design/dmu_upper_ctrl.sv
// Control, status and request logic of the word transfer controller
`timescale 1ns/10ps
`default_nettype none
module dmu_upper_ctrl
  import dmu_pkg::*;
#(
  parameter int SWQ_W = 2
)(
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic [7:0]         io_addr,
  input  wire logic [7:0]         io_wdata,
  input  wire logic               io_rd,
  input  wire logic               io_wr,
  output logic [7:0]              io_rdata,
  input  wire logic [NCH-1:0]     transfer_request_in,
  input  wire logic [NCH-1:0]     last_word_in,
  output logic [NCH-1:0]          transfer_grant_out,
  output logic [SEL_W-1:0]        active_channel,
  output logic                    cmd_strobe,
  output logic                    tc_strobe,
  output logic                    mem_to_mem_en,
  output logic                    chan0_addr_hold,
  output logic [NCH*8-1:0]        channel_mode_out
);

  // Queue counter must fit its saturating increment
  if (SWQ_W < 1 || SWQ_W > 8) begin : g_bad_swq
    $error("SWQ_W must lie between 1 and 8");
  end

  typedef enum logic [2:0] {
    MS_ARB  = 3'b001,
    MS_XFER = 3'b010,
    MS_CASC = 3'b100
  } dmu_main_e;

  ////////////////////////////////////////////////////////////////////////
  // Port decode

  logic             wr_cmd;
  logic             wr_swreq;
  logic             wr_mask1;
  logic             wr_mode;
  logic             wr_mclr;
  logic             wr_mask_clr;
  logic             wr_mask_all;
  logic             rd_stat;
  logic [SEL_W-1:0] wsel;

  assign wr_cmd      = io_wr && (io_addr == ADDR_STAT_CMD);
  assign wr_swreq    = io_wr && (io_addr == ADDR_SWREQ);
  assign wr_mask1    = io_wr && (io_addr == ADDR_MASK1);
  assign wr_mode     = io_wr && (io_addr == ADDR_MODE);
  assign wr_mclr     = io_wr && (io_addr == ADDR_MCLR);
  assign wr_mask_clr = io_wr && (io_addr == ADDR_MASK_CLR);
  assign wr_mask_all = io_wr && (io_addr == ADDR_MASK_ALL);
  assign rd_stat     = io_rd && (io_addr == ADDR_STAT_CMD);
  assign wsel        = io_wdata[SEL_LSB +: SEL_W];

  ////////////////////////////////////////////////////////////////////////
  // Command, mask, status and read data

  logic [7:0]     cmd_reg;
  logic [7:0]     cmd_next;
  logic [NCH-1:0] mask_reg;
  logic [NCH-1:0] mask_next;
  logic [NCH-1:0] pend_reg;
  logic [NCH-1:0] pend_next;
  logic [NCH-1:0] tc_reg;
  logic [NCH-1:0] tc_next;
  logic [7:0]     rdata_reg;
  logic [7:0]     rdata_next;
  logic [NCH-1:0] req_hw;
  logic [NCH-1:0] sw_pend;
  logic [NCH-1:0] tc_set;
  logic [NCH-1:0] eligible;

  // Active-high view of the request pins
  assign req_hw   = cmd_reg[CMD_REQ_LO] ? ~transfer_request_in : transfer_request_in;
  assign eligible = (req_hw & ~mask_reg) | sw_pend;

  always_comb begin
    cmd_next   = cmd_reg;
    mask_next  = mask_reg;
    pend_next  = req_hw | sw_pend;
    tc_next    = tc_reg;
    rdata_next = rdata_reg;
    if (wr_cmd) begin
      cmd_next = io_wdata & CMD_WMASK;
    end
    if (wr_mask1) begin
      mask_next[wsel] = io_wdata[MASK_SET_BIT];
    end
    if (wr_mask_clr) begin
      mask_next = MASK_RESET;
    end
    if (wr_mask_all) begin
      mask_next = io_wdata[NCH-1:0];
    end
    if (io_rd) begin
      if (io_addr == ADDR_STAT_CMD) begin
        rdata_next = (8'(pend_reg) << ST_REQ_LSB) | (8'(tc_reg) << ST_TC_LSB);
      end else if (io_addr == ADDR_MASK_ALL) begin
        rdata_next = 8'(mask_reg);
      end else begin
        rdata_next = UNDEF_RDATA;
      end
    end
    if (rd_stat) begin
      tc_next = TC_RESET;
    end
    // A count reached in the read cycle survives the read
    tc_next = tc_next | tc_set;
    if (wr_mclr) begin
      cmd_next  = CMD_RESET;
      mask_next = MASK_ALL_SET;
      pend_next = '0;
      tc_next   = TC_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_reg   <= CMD_RESET;
      mask_reg  <= MASK_RESET;
      pend_reg  <= '0;
      tc_reg    <= TC_RESET;
      rdata_reg <= RDATA_RESET;
    end else begin
      cmd_reg   <= cmd_next;
      mask_reg  <= mask_next;
      pend_reg  <= pend_next;
      tc_reg    <= tc_next;
      rdata_reg <= rdata_next;
    end
  end

  assign io_rdata        = rdata_reg;
  assign mem_to_mem_en   = cmd_reg[CMD_MEM2MEM];
  assign chan0_addr_hold = cmd_reg[CMD_MEM2MEM] && cmd_reg[CMD_ADDR_HOLD];

  ////////////////////////////////////////////////////////////////////////
  // Per-channel mode registers and software request counts

  logic [7:0]       mode_reg [NCH];
  logic [7:0]       mode_next [NCH];
  logic [SWQ_W-1:0] swq_reg [NCH];
  logic [SWQ_W-1:0] swq_next [NCH];
  logic [NCH-1:0]   consume;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    always_comb begin
      mode_next[i] = mode_reg[i];
      swq_next[i]  = swq_reg[i];
      if (wr_mode && wsel == SEL_W'(i)) begin
        mode_next[i] = io_wdata;
      end
      if (consume[i] && swq_reg[i] != '0) begin
        swq_next[i] = SWQ_W'(swq_reg[i] - 1'b1);
      end
      if (wr_swreq && io_wdata[REQ_GO_BIT] && wsel == SEL_W'(i) && swq_next[i] != '1) begin
        swq_next[i] = SWQ_W'(swq_next[i] + 1'b1);
      end
      if (wr_mclr) begin
        swq_next[i] = '0;
      end
    end

    always_ff @(posedge core_clk) begin
      if (srst) begin
        mode_reg[i] <= MODE_RESET;
        swq_reg[i]  <= '0;
      end else begin
        mode_reg[i] <= mode_next[i];
        swq_reg[i]  <= swq_next[i];
      end
    end

    assign sw_pend[i]                  = (swq_reg[i] != '0);
    assign channel_mode_out[i*8 +: 8] = mode_reg[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // Arbitration and transfer sequencing

  logic             win_valid;
  logic [SEL_W-1:0] win_ch;
  logic             arb_take;
  logic             seq_start;
  logic             seq_done;
  logic             seq_tc;
  dmu_main_e        st_reg;
  dmu_main_e        st_next;
  logic [SEL_W-1:0] ch_reg;
  logic [SEL_W-1:0] ch_next;
  logic [NCH-1:0]   grant_reg;
  logic [NCH-1:0]   grant_next;
  logic [NCH-1:0]   grant_act;
  logic [1:0]       cur_mode;
  logic             m2m_first;

  dmu_arbiter u_arb (
    .core_clk  (core_clk),
    .srst      (srst),
    .req       (eligible),
    .rotate    (cmd_reg[CMD_ROTATE]),
    .take      (arb_take),
    .taken_ch  (win_ch),
    .win_valid (win_valid),
    .win_ch    (win_ch)
  );

  dmu_sequencer u_seq (
    .core_clk   (core_clk),
    .srst       (srst),
    .start      (seq_start),
    .abort      (wr_mclr),
    .compressed (cmd_reg[CMD_COMPRESS]),
    .last_word  (last_word_in[ch_reg]),
    .done       (seq_done),
    .cmd_strobe (cmd_strobe),
    .tc_strobe  (seq_tc)
  );

  assign tc_strobe = seq_tc;

  assign cur_mode  = mode_reg[ch_reg][MODE_SEL_LSB +: 2];
  assign m2m_first = cmd_reg[CMD_MEM2MEM] && (ch_reg == '0);

  always_comb begin
    st_next   = st_reg;
    ch_next   = ch_reg;
    seq_start = 1'b0;
    arb_take  = 1'b0;
    tc_set    = '0;
    consume   = '0;
    unique case (st_reg)
      MS_ARB: begin
        if (!cmd_reg[CMD_DISABLE] && win_valid) begin
          ch_next  = win_ch;
          arb_take = 1'b1;
          if (mode_reg[win_ch][MODE_SEL_LSB +: 2] == MODE_CASCADE) begin
            st_next = MS_CASC;
          end else begin
            seq_start = 1'b1;
            st_next   = MS_XFER;
          end
        end
      end
      MS_XFER: begin
        if (seq_done) begin
          consume[ch_reg] = 1'b1;
          tc_set[ch_reg]  = last_word_in[ch_reg];
          if (m2m_first) begin
            // Source read done, run the destination write
            ch_next   = SEL_W'(1);
            seq_start = 1'b1;
          end else if (!last_word_in[ch_reg] && !cmd_reg[CMD_DISABLE] &&
                       (cur_mode == MODE_BLOCK || (cur_mode == MODE_DEMAND && eligible[ch_reg]))) begin
            seq_start = 1'b1;
          end else begin
            st_next = MS_ARB;
          end
        end
      end
      MS_CASC: begin
        if (!req_hw[ch_reg]) begin
          st_next = MS_ARB;
        end
      end
    endcase
    if (wr_mclr) begin
      st_next   = MS_ARB;
      seq_start = 1'b0;
    end
    for (int i = 0; i < NCH; i++) begin
      grant_act[i] = (st_next != MS_ARB) && (ch_next == SEL_W'(i));
    end
    grant_next = cmd_next[CMD_ACK_HI] ? grant_act : ~grant_act;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg    <= MS_ARB;
      ch_reg    <= '0;
      grant_reg <= MASK_ALL_SET;
    end else begin
      st_reg    <= st_next;
      ch_reg    <= ch_next;
      grant_reg <= grant_next;
    end
  end

  assign transfer_grant_out = grant_reg;
  assign active_channel     = ch_reg;

endmodule
`default_nettype wire

// ===== testbench/dmu_upper_ctrl_assertions.sv
// Checker for the upper-channel DMA control port
`timescale 1ns/10ps
`default_nettype none
module dmu_upper_ctrl_chk
  import dmu_pkg::*;
#(
  parameter int SWQ_W = 2
)(
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [7:0]       io_addr,
  input  wire logic [7:0]       io_wdata,
  input  wire logic             io_rd,
  input  wire logic             io_wr,
  input  wire logic [7:0]       io_rdata,
  input  wire logic [NCH-1:0]   transfer_request_in,
  input  wire logic [NCH-1:0]   transfer_grant_out,
  input  wire logic             cmd_strobe,
  input  wire logic             tc_strobe,
  input  wire logic             mem_to_mem_en,
  input  wire logic             chan0_addr_hold,
  input  wire logic [NCH*8-1:0] channel_mode_out
);
  logic [7:0]     cmd_reg;
  logic [7:0]     cmd_next;
  logic [1:0]     cw_reg;
  logic           st_rd;
  logic           mclr;
  logic           cmd_wr;
  logic [NCH-1:0] gact;
  logic [NCH-1:0] nreq;
  assign st_rd = io_rd && io_addr == ADDR_STAT_CMD;
  assign cmd_wr = io_wr && io_addr == ADDR_STAT_CMD;
  assign mclr = io_wr && io_addr == ADDR_MCLR;
  assign gact = cmd_reg[CMD_ACK_HI] ? transfer_grant_out : ~transfer_grant_out;
  assign nreq = transfer_request_in ^ {NCH{cmd_reg[CMD_REQ_LO]}};
  always_comb begin
    cmd_next = cmd_reg;
    if (cmd_wr) begin
      cmd_next = io_wdata;
    end
    if (mclr) begin
      cmd_next = 8'h00;
    end
  end
  always_ff @(posedge core_clk) begin
    cmd_reg <= srst ? 8'h00 : cmd_next;
    cw_reg <= srst ? 2'h0 : {cw_reg[0], cmd_wr};
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  stat_pend_a: assert property (
    st_rd && !$past(srst) && !$past(mclr) && nreq == $past(nreq) |=> (io_rdata[7:4] & $past(nreq)) == $past(nreq))
    else $error("pending status misses a request");
  tc_clear_a: assert property (
    st_rd && !tc_strobe && !$past(tc_strobe) && !$past(tc_strobe, 2) ##2 st_rd && !tc_strobe && !$past(tc_strobe)
    |=> io_rdata[3:0] == 4'h0) else $error("count bits survive a status read");
  mclr_idle_a: assert property (
    mclr ##1 !io_wr |=> transfer_grant_out == 4'hF && !mem_to_mem_en && !chan0_addr_hold)
    else $error("master clear left controller active");
  cmd_bits_a: assert property (
    cmd_wr ##1 !io_wr |=> mem_to_mem_en == $past(io_wdata[0], 2) && chan0_addr_hold == &$past(io_wdata[1:0], 2))
    else $error("command bits 1:0 not applied");
  mode_ch7_a: assert property (
    io_wr && io_addr == ADDR_MODE && io_wdata[1:0] == 2'h3 |=> channel_mode_out[31:24] == $past(io_wdata))
    else $error("mode write not applied");
  no_start_a: assert property (
    cmd_reg[CMD_DISABLE] && cw_reg == 2'h0 && gact == 4'h0 |=> gact == 4'h0)
    else $error("transfer started while disabled");
  one_grant_a: assert property (
    cw_reg == 2'h0 |-> $onehot0(gact)) else $error("more than one grant active");
  strobe_grant_a: assert property (
    cmd_strobe && cw_reg == 2'h0 |-> gact != 4'h0) else $error("strobe without grant");
  norm_time_a: assert property (
    $rose(gact != 4'h0) && cw_reg == 2'h0 && !cmd_reg[CMD_COMPRESS] |-> !cmd_strobe ##1 !cmd_strobe ##1 cmd_strobe [*2])
    else $error("normal transfer timing wrong");
  comp_time_a: assert property (
    $rose(gact != 4'h0) && cw_reg == 2'h0 && cmd_reg[CMD_COMPRESS] |-> !cmd_strobe ##1 cmd_strobe [*2])
    else $error("compressed transfer timing wrong");
endmodule
bind dmu_upper_ctrl dmu_upper_ctrl_chk #(.SWQ_W(SWQ_W)) dmu_upper_ctrl_chk_i (
  .core_clk(core_clk), .srst(srst), .io_addr(io_addr), .io_wdata(io_wdata), .io_rd(io_rd), .io_wr(io_wr),
  .io_rdata(io_rdata), .transfer_request_in(transfer_request_in), .transfer_grant_out(transfer_grant_out),
  .cmd_strobe(cmd_strobe), .tc_strobe(tc_strobe), .mem_to_mem_en(mem_to_mem_en),
  .chan0_addr_hold(chan0_addr_hold), .channel_mode_out(channel_mode_out)
);
`default_nettype wire

// ===== testbench/dmu_periph_model.sv
// Peripheral model: holds a request until its grant is seen
`timescale 1ns/10ps
`default_nettype none
module dmu_periph_model
  import dmu_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic [NCH-1:0] arm,
  input  wire logic           req_low,
  input  wire logic           ack_high,
  input  wire logic [NCH-1:0] transfer_grant_out,
  input  wire logic [NCH-1:0] last_in,
  output logic [NCH-1:0]      transfer_request_in,
  output logic [NCH-1:0]      last_word_in
);
  logic [NCH-1:0] served_reg;
  logic [NCH-1:0] served_next;
  logic [NCH-1:0] granted;
  assign granted = ack_high ? transfer_grant_out : ~transfer_grant_out;
  always_comb begin
    served_next = arm & (served_reg | granted);
  end
  always_ff @(posedge core_clk) begin
    served_reg <= served_next;
  end
  assign transfer_request_in = (arm & ~served_reg) ^ {NCH{req_low}};
  // Count block view: which channel is on its last word
  assign last_word_in = last_in;
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the upper-channel DMA control port
`timescale 1ns/10ps
`default_nettype none
module testbench
  import dmu_pkg::*;
;
  logic           core_clk = 1'b0;
  logic           srst = 1'b1;
  logic [7:0]     io_addr = 8'h00;
  logic [7:0]     io_wdata = 8'h00;
  logic           io_rd = 1'b0;
  logic           io_wr = 1'b0;
  logic [NCH-1:0] arm = 4'h0;
  logic           req_low = 1'b0;
  logic           ack_high = 1'b0;
  logic [NCH-1:0] last_set = 4'hF;
  logic [7:0]     io_rdata;
  logic [NCH-1:0] treq;
  logic [NCH-1:0] lastw;
  logic [NCH-1:0] grant;
  logic [1:0]     act_ch;
  logic           m2m;
  logic           hold;
  logic           tc_s;
  logic [31:0]    modes;
  logic           rd_pend = 1'b0;
  logic [15:0]    re;
  logic [5:0]     te;
  logic [7:0]     md;
  logic [15:0]    rdq[$];
  logic [5:0]     tcq[$];
  logic [7:0]     wo[4] = '{ADDR_SWREQ, ADDR_MASK1, ADDR_MODE, 8'hD8};
  int             errors = 0;
  int             n_compared = 0;
  int             seed = 32'h6ECF;

  always #4 core_clk = ~core_clk;

  dmu_upper_ctrl #(.SWQ_W(2)) dmu_upper_ctrl_i (
    .core_clk(core_clk), .srst(srst), .io_addr(io_addr), .io_wdata(io_wdata), .io_rd(io_rd), .io_wr(io_wr),
    .io_rdata(io_rdata), .transfer_request_in(treq), .last_word_in(lastw), .transfer_grant_out(grant),
    .active_channel(act_ch), .cmd_strobe(), .tc_strobe(tc_s), .mem_to_mem_en(m2m),
    .chan0_addr_hold(hold), .channel_mode_out(modes)
  );
  dmu_periph_model dmu_periph_model_i (
    .core_clk(core_clk), .arm(arm), .req_low(req_low), .ack_high(ack_high), .last_in(last_set),
    .transfer_grant_out(grant), .transfer_request_in(treq), .last_word_in(lastw)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m, input string what);
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    io_wr = wr;
    io_rd = !wr;
    io_addr = a;
    io_wdata = d;
    @(posedge core_clk);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    rdq.push_back({e, m});
    io(1'b0, a, 8'h00);
  endtask
  function automatic logic [5:0] tnote(input int ch, input logic hi);
    logic [3:0] g;
    g = 4'h1 << ch;
    return {ch[1:0], hi ? g : ~g};
  endfunction
  task automatic drain();
    for (int i = 0; i < 300 && tcq.size() > 0; i++) @(posedge core_clk);
    if (tcq.size() > 0) begin
      errors++;
      $display("MISMATCH %0t transfer never finished", $time);
      summarize();
    end
    repeat (8) @(posedge core_clk);
  endtask
  // Monitor: read data and finished transfers against noted expectations
  always @(posedge core_clk) begin
    if (rd_pend) begin
      re = rdq.pop_front();
      cmp(io_rdata, re[15:8], re[7:0], "read data");
    end
    if (tc_s) begin
      te = (tcq.size() == 0) ? 6'h3F : tcq.pop_front();
      cmp({2'h0, act_ch, grant}, {2'h0, te}, 8'hFF, "served channel");
    end
    rd_pend = io_rd;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    srst = 1'b0;
    cmp({4'h0, grant}, 8'h0F, 8'hFF, "idle grant");
    rd(ADDR_STAT_CMD, 8'h00, 8'hFF);
    foreach (wo[i]) rd(wo[i], UNDEF_RDATA, 8'hFF);
    $display("test reset done");
    io(1'b1, ADDR_STAT_CMD, 8'h04);
    for (int i = 0; i < 4; i++) io(1'b1, ADDR_MODE, 8'h40 | i[7:0]);
    io(1'b1, ADDR_SWREQ, 8'h07);
    io(1'b1, ADDR_SWREQ, 8'h05);
    io(1'b1, ADDR_SWREQ, 8'h06);
    rd(ADDR_STAT_CMD, 8'hE0, 8'hF0);
    for (int c = 1; c < 4; c++) tcq.push_back(tnote(c, 1'b0));
    io(1'b1, ADDR_STAT_CMD, 8'h00);
    drain();
    rd(ADDR_STAT_CMD, 8'h0E, 8'hFF);
    rd(ADDR_STAT_CMD, 8'h00, 8'hFF);
    $display("test fixed priority done");
    io(1'b1, ADDR_STAT_CMD, 8'h14);
    io(1'b1, ADDR_SWREQ, 8'h04);
    io(1'b1, ADDR_SWREQ, 8'h04);
    io(1'b1, ADDR_SWREQ, 8'h05);
    tcq.push_back(tnote(0, 1'b0));
    tcq.push_back(tnote(1, 1'b0));
    tcq.push_back(tnote(0, 1'b0));
    io(1'b1, ADDR_STAT_CMD, 8'h10);
    drain();
    rd(ADDR_STAT_CMD, 8'h03, 8'hFF);
    $display("test rotating priority done");
    io(1'b1, ADDR_STAT_CMD, 8'h88);
    ack_high = 1'b1;
    cmp({4'h0, grant}, 8'h00, 8'hFF, "idle grant high");
    tcq.push_back(tnote(3, 1'b1));
    io(1'b1, ADDR_SWREQ, 8'h07);
    drain();
    rd(ADDR_STAT_CMD, 8'h08, 8'hFF);
    io(1'b1, ADDR_STAT_CMD, 8'h00);
    ack_high = 1'b0;
    $display("test compressed done");
    io(1'b1, ADDR_MASK_ALL, 8'h0F);
    arm = 4'h6;
    repeat (3) @(posedge core_clk);
    rd(ADDR_STAT_CMD, 8'h60, 8'hF0);
    tcq.push_back(tnote(2, 1'b0));
    io(1'b1, ADDR_MASK1, 8'h02);
    drain();
    rd(ADDR_MASK_ALL, 8'h0B, 8'h0F);
    io(1'b1, ADDR_MASK1, 8'h06);
    rd(ADDR_MASK_ALL, 8'h0F, 8'h0F);
    io(1'b1, ADDR_STAT_CMD, 8'h40);
    req_low = 1'b1;
    rd(ADDR_STAT_CMD, 8'h20, 8'hF0);
    arm = 4'h0;
    rd(ADDR_STAT_CMD, 8'h00, 8'hF0);
    io(1'b1, ADDR_STAT_CMD, 8'h00);
    req_low = 1'b0;
    $display("test hardware requests done");
    io(1'b1, ADDR_STAT_CMD, 8'h01);
    tcq.push_back(tnote(0, 1'b0));
    tcq.push_back(tnote(1, 1'b0));
    io(1'b1, ADDR_SWREQ, 8'h04);
    drain();
    rd(ADDR_STAT_CMD, 8'h03, 8'hFF);
    last_set = 4'h7;
    io(1'b1, ADDR_SWREQ, 8'h07);
    repeat (8) @(posedge core_clk);
    rd(ADDR_STAT_CMD, 8'h00, 8'hFF);
    cmp({6'h0, act_ch}, 8'h03, 8'hFF, "last channel");
    last_set = 4'hF;
    $display("test paired and short transfers done");
    io(1'b1, ADDR_STAT_CMD, 8'h03);
    cmp({6'h0, m2m, hold}, 8'h03, 8'hFF, "command bits");
    io(1'b1, ADDR_MCLR, 8'($random(seed)));
    cmp({2'h0, m2m, hold, grant}, 8'h0F, 8'hFF, "after clear");
    rd(ADDR_MASK_ALL, 8'h0F, 8'h0F);
    $display("test master clear done");
    for (int i = 0; i < 4; i++) begin
      md = {6'($random(seed)), i[1:0]};
      io(1'b1, ADDR_MODE, md);
      cmp(modes[i*8 +: 8], md, 8'hFF, "mode");
    end
    $display("test modes done");
    summarize();
  end
endmodule
`default_nettype wire
